// >>> dv/dac_model.sv
// Metering DAC model that keeps the peak sample magnitude
`timescale 1ns/1ns
`default_nettype none
module dac_model (
    // Clock and clear
    input  wire        aclk,
    input  wire        clr,
    // Sample stream
    input  wire [15:0] dac_data,
    input  wire        dac_strobe,
    // Observation
    output logic [15:0] peak
);
    wire [15:0] mag = dac_data[15] ? 16'h0000 - dac_data : dac_data;
    always @(posedge aclk) begin
        if (clr)
            peak <= 16'h0000;
        else if (dac_strobe && mag > peak)
            peak <= mag;
    end
endmodule // dac_model
`default_nettype wire

// >>> dv/tone_gen_bench.sv
// Self-checking bench for the billing tone generator
`timescale 1ns/1ns
`default_nettype none
`include "tone_gen_map.vh"
module tone_gen_bench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        clr = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] v;
    logic [1:0]  rs;
    logic [15:0] tx_level = 16'h0000;
    wire         awready, wready, bvalid, arready, rvalid, irq_n, dac_strobe;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [15:0] dac_data, peak;
    int          n_errors = 0;
    int          comparisons = 0;
    initial forever #20 aclk = ~aclk;
    tone_gen #(.SAMPLE_DIV(4)) tone_gen_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .tx_level(tx_level), .dac_data(dac_data),
        .dac_strobe(dac_strobe), .irq_n(irq_n));
    dac_model dac_model_i (.aclk(aclk), .clr(clr), .dac_data(dac_data),
        .dac_strobe(dac_strobe), .peak(peak));
    task chk(input string nm, input [31:0] e, input [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        int t;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        t = 0;
        do begin
            @(negedge aclk);
            ta = awready;
            tw = wready;
            tb = bvalid;
            r = bresp;
            t++;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb && t < 100);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {31'h0, tb} ? {30'h0, r} : 32'hf);
    endtask
    task rd(input [7:0] a);
        logic ta, tb;
        int t;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        t = 0;
        do begin
            @(negedge aclk);
            ta = arready;
            tb = rvalid;
            v = rdata;
            rs = rresp;
            t++;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tb && t < 100);
        rready <= 1'b0;
        if (!tb) rs = 2'b11;
        chk("rvalid", 1, {31'h0, tb});
    endtask
    task results;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        n_errors++;
        results;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        clr     <= 1'b0;
        rd(`OFS_CONTROL);
        chk("control", 0, v);
        rd(`OFS_IRQ_STATUS);
        chk("status", 0, v);
        chk("irq_n", 1, {31'h0, irq_n});
        rd(8'h28);
        chk("rresp", 2, {30'h0, rs});
        wr(`OFS_IRQ_STATUS, 3, 2'b10);
        wr(`OFS_ON_TIME, 32'h1ffff, 0);
        rd(`OFS_ON_TIME);
        chk("on_duration", 32'hffff, v);
        $display("test registers done");
        wr(`OFS_FREQ, 32'h187e, 0);
        wr(`OFS_AMPL, 32'h1000, 0);
        wr(`OFS_STEP, 32'h1000, 0);
        wr(`OFS_CLIP, 32'hffff, 0);
        wr(`OFS_CONTROL, 1, 0);
        repeat (100) @(posedge aclk);
        rd(`OFS_VOLUME);
        chk("attack", 1, v[11:0] == 0 && v > 0 && v < 32'h7fff);
        repeat (400) @(posedge aclk);
        rd(`OFS_VOLUME);
        chk("volume max", 32'h7fff, v);
        rd(`OFS_CONTROL);
        chk("present", 32'h9, v);
        // Seed 1000h at 67.5 deg per sample (12 kHz only at 64 kHz) peaks near 1000h / sin(67.5 deg)
        chk("dac peak", 1, peak > 16'h1100 && peak < 16'h1200);
        wr(`OFS_CONTROL, 0, 0);
        repeat (100) @(posedge aclk);
        rd(`OFS_VOLUME);
        chk("decay", 1, v[11:0] == 12'hfff && v < 32'h7fff);
        repeat (400) @(posedge aclk);
        rd(`OFS_VOLUME);
        chk("volume zero", 0, v);
        $display("test envelope done");
        wr(`OFS_CLIP, 32'h0100, 0);
        tx_level <= 16'h0200;
        wr(`OFS_CONTROL, 1, 0);
        repeat (200) @(posedge aclk);
        rd(`OFS_VOLUME);
        chk("frozen", 0, v);
        tx_level <= 16'h0000;
        repeat (100) @(posedge aclk);
        rd(`OFS_VOLUME);
        chk("released", 1, {31'h0, v != 0});
        $display("test clip done");
        // Dropping the tone reloads the cadence counter
        wr(`OFS_CONTROL, 0, 0);
        wr(`OFS_ON_TIME, 2, 0);
        wr(`OFS_OFF_TIME, 1, 0);
        wr(`OFS_IRQ_MASK, 3, 0);
        wr(`OFS_CONTROL, 7, 0);
        repeat (250) @(posedge aclk);
        chk("irq_n low", 0, {31'h0, irq_n});
        wr(`OFS_CONTROL, 0, 0);
        rd(`OFS_IRQ_STATUS);
        chk("both expiries", 3, v);
        rd(`OFS_IRQ_STATUS);
        chk("cleared", 0, v);
        chk("irq_n high", 1, {31'h0, irq_n});
        wr(`OFS_IRQ_MASK, 1, 0);
        wr(`OFS_CONTROL, 7, 0);
        repeat (250) @(posedge aclk);
        wr(`OFS_CONTROL, 0, 0);
        rd(`OFS_IRQ_STATUS);
        chk("masked", 1, v);
        wr(`OFS_IRQ_MASK, 3, 0);
        wr(`OFS_CONTROL, 3, 0);
        repeat (250) @(posedge aclk);
        wr(`OFS_CONTROL, 0, 0);
        rd(`OFS_IRQ_STATUS);
        chk("on only", 1, v);
        $display("test cadence done");
        results;
    end
endmodule // tone_gen_bench
`default_nettype wire

// >>> dv/tone_gen_monitor.sv
// Port checker for the billing tone generator
`timescale 1ns/1ns
`default_nettype none
`include "tone_gen_map.vh"
module tone_gen_monitor #(
    parameter SAMPLE_DIV = 390
) (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Register bus
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    // Tone and interrupt
    input wire [15:0] dac_data,
    input wire        dac_strobe,
    input wire        irq_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    logic [15:0] gap;
    logic        seen;
    // Cycles since the last sample
    always @(posedge aclk) begin
        if (!aresetn) begin
            gap  <= 16'h0000;
            seen <= 1'b0;
        end else begin
            gap  <= dac_strobe ? 16'h0000 : gap + 16'h0001;
            seen <= seen | dac_strobe;
        end
    end
    property p_rate; dac_strobe && seen |-> gap == SAMPLE_DIV - 1; endproperty
    a_rate: assert property (p_rate) else $error("sample spacing");
    property p_dac; $changed(dac_data) && $past(aresetn) |-> dac_strobe;
    endproperty
    a_dac: assert property (p_dac) else $error("dac off strobe");
    property p_clr; $rose(irq_n) && $past(aresetn)
        |-> $past(rd_take && s_axi_araddr == `OFS_IRQ_STATUS); endproperty
    a_clr: assert property (p_clr) else $error("irq cleared alone");
    property p_wr; wr_take |=> s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("no write response");
    property p_rd; rd_take |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("no read response");
    property p_bb; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bb: assert property (p_bb) else $error("write taken early");
    property p_rb; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rb: assert property (p_rb) else $error("read taken early");
    property p_bad; rd_take && s_axi_araddr > `OFS_VOLUME
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0; endproperty
    a_bad: assert property (p_bad) else $error("unmapped read");
    property p_ro; wr_take && s_axi_awaddr == `OFS_IRQ_STATUS
        |=> s_axi_bresp == 2'b10; endproperty
    a_ro: assert property (p_ro) else $error("status write ok");
endmodule // tone_gen_monitor
bind tone_gen tone_gen_monitor #(.SAMPLE_DIV(SAMPLE_DIV)) tone_gen_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .dac_data(dac_data), .dac_strobe(dac_strobe), .irq_n(irq_n));
`default_nettype wire

// >>> rtl/tone_gen.v
// Billing tone generator with envelope, cadence timers and AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "tone_gen_map.vh"
module tone_gen #(
    parameter SAMPLE_DIV = `SAMPLE_DIV
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Transmit path level and DAC output
    input  wire [15:0] tx_level,
    output reg  [15:0] dac_data,
    output reg         dac_strobe,
    // Interrupt, active low
    output wire        irq_n
);
    reg [15:0] tone_freq_coeff_reg;
    reg [15:0] tone_ampl_coeff_reg;
    reg [15:0] envelope_step_reg;
    reg [15:0] agc_clip_threshold_reg;
    reg [15:0] on_duration_reg;
    reg [15:0] off_duration_reg;
    reg [2:0]  control_reg;
    reg [1:0]  irq_status_one_reg;
    reg [1:0]  irq_mask_one_reg;
    reg [15:0] volume_reg;
    reg [15:0] div_reg;
    reg [2:0]  tick_cnt_reg;
    reg        sample_reg;
    reg        tick_reg;
    reg signed [15:0] y1_reg;
    reg signed [15:0] y2_reg;
    reg        osc_run_reg;
    reg        phase_on_reg;
    reg [15:0] cadence_reg;
    reg        aw_held_reg;
    reg        w_held_reg;
    reg [7:0]  awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;

    wire tone_en    = control_reg[`CTL_TONE_EN];
    wire on_tmr_en  = control_reg[`CTL_ON_TMR_EN];
    wire off_tmr_en = control_reg[`CTL_OFF_TMR_EN];
    // Waveform present while the envelope is open
    wire present    = (volume_reg != 16'h0000);
    wire gate_on    = tone_en & phase_on_reg;

    // Write channels taken independently
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
    wire aw_ok = aw_held_reg | (s_axi_awvalid & s_axi_awready);
    wire w_ok  = w_held_reg | (s_axi_wvalid & s_axi_wready);
    wire [7:0]  wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0]  ws = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire do_write  = aw_ok & w_ok;
    wire [15:0] wmask = {{8{ws[1]}}, {8{ws[0]}}};
    // Status and volume are read only
    wire wr_addr_ok = (wa <= `OFS_IRQ_MASK) && (wa[1:0] == 2'b00) &&
                      (wa != `OFS_IRQ_STATUS);
    assign s_axi_arready = ~s_axi_rvalid;
    wire do_read = s_axi_arvalid & s_axi_arready;
    wire rd_status = do_read && (s_axi_araddr == `OFS_IRQ_STATUS);

    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [15:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h00000000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid & s_axi_awready & ~do_write) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~do_write) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_addr_ok ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            control_reg            <= 3'h0;
            tone_freq_coeff_reg    <= 16'h0000;
            tone_ampl_coeff_reg    <= 16'h0000;
            envelope_step_reg      <= 16'h0000;
            agc_clip_threshold_reg <= 16'h0000;
            on_duration_reg        <= 16'h0000;
            off_duration_reg       <= 16'h0000;
            irq_mask_one_reg       <= 2'h0;
        end else if (do_write) begin
            case (wa)
                `OFS_CONTROL: if (ws[0])
                    control_reg <= wd[2:0];
                `OFS_FREQ: tone_freq_coeff_reg <=
                    merge(tone_freq_coeff_reg, wd[15:0], wmask);
                `OFS_AMPL: tone_ampl_coeff_reg <=
                    merge(tone_ampl_coeff_reg, wd[15:0], wmask);
                `OFS_STEP: envelope_step_reg <=
                    merge(envelope_step_reg, wd[15:0], wmask);
                `OFS_CLIP: agc_clip_threshold_reg <=
                    merge(agc_clip_threshold_reg, wd[15:0], wmask);
                `OFS_ON_TIME: on_duration_reg <=
                    merge(on_duration_reg, wd[15:0], wmask);
                `OFS_OFF_TIME: off_duration_reg <=
                    merge(off_duration_reg, wd[15:0], wmask);
                `OFS_IRQ_MASK: if (ws[0])
                    irq_mask_one_reg <= wd[1:0];
                default: ;
            endcase
        end
    end

    // Register reads
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
                `OFS_CONTROL:    s_axi_rdata <= {28'h0, present, control_reg};
                `OFS_FREQ:       s_axi_rdata <= {16'h0, tone_freq_coeff_reg};
                `OFS_AMPL:       s_axi_rdata <= {16'h0, tone_ampl_coeff_reg};
                `OFS_STEP:       s_axi_rdata <= {16'h0, envelope_step_reg};
                `OFS_CLIP:       s_axi_rdata <= {16'h0, agc_clip_threshold_reg};
                `OFS_ON_TIME:    s_axi_rdata <= {16'h0, on_duration_reg};
                `OFS_OFF_TIME:   s_axi_rdata <= {16'h0, off_duration_reg};
                `OFS_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status_one_reg};
                `OFS_IRQ_MASK:   s_axi_rdata <= {30'h0, irq_mask_one_reg};
                `OFS_VOLUME:     s_axi_rdata <= {16'h0, volume_reg};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // 64 kHz sample and 8 kHz tick strobes
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_reg      <= 16'h0000;
            tick_cnt_reg <= 3'h0;
            sample_reg   <= 1'b0;
            tick_reg     <= 1'b0;
        end else begin
            sample_reg <= 1'b0;
            tick_reg   <= 1'b0;
            if (div_reg == SAMPLE_DIV[15:0] - 16'h0001) begin
                div_reg    <= 16'h0000;
                sample_reg <= 1'b1;
                tick_cnt_reg <= tick_cnt_reg + 3'h1;
                if (tick_cnt_reg == 3'h7)
                    tick_reg <= 1'b1;
            end else begin
                div_reg <= div_reg + 16'h0001;
            end
        end
    end

    // Recursive oscillator y = 2c*y1 - y2
    wire signed [16:0] c_s  = {1'b0, tone_freq_coeff_reg};
    wire signed [33:0] prod = y1_reg * c_s;
    // One left shift makes 2c*y1 with c in Q14
    wire signed [33:0] acc  = (prod <<< 1) - {{4{y2_reg[15]}}, y2_reg, 14'h0};
    wire signed [15:0] y0   = acc[29:14];

    always @(posedge aclk) begin
        if (!aresetn) begin
            y1_reg      <= 16'sh0000;
            y2_reg      <= 16'sh0000;
            osc_run_reg <= 1'b0;
        end else if (sample_reg) begin
            if (!present && !gate_on) begin
                osc_run_reg <= 1'b0;
                y1_reg      <= 16'sh0000;
                y2_reg      <= 16'sh0000;
            end else if (!osc_run_reg) begin
                osc_run_reg <= 1'b1;
                y1_reg      <= tone_ampl_coeff_reg;
                y2_reg      <= 16'sh0000;
            end else begin
                y1_reg <= y0;
                y2_reg <= y1_reg;
            end
        end
    end

    wire signed [16:0] vol_s = {1'b0, volume_reg};
    wire signed [32:0] shaped = y1_reg * vol_s;
    always @(posedge aclk) begin
        if (!aresetn) begin
            dac_data   <= 16'h0000;
            dac_strobe <= 1'b0;
        end else begin
            dac_strobe <= sample_reg;
            if (sample_reg)
                dac_data <= shaped[30:15];
        end
    end

    // Envelope with saturation
    wire [16:0] up = {1'b0, volume_reg} + {1'b0, envelope_step_reg};
    reg  [15:0] volume_next;
    always @* begin
        volume_next = volume_reg;
        if (tick_reg) begin
            if (gate_on) begin
                if (tx_level <= agc_clip_threshold_reg) begin
                    if (up > {1'b0, `VOL_MAX})
                        volume_next = `VOL_MAX;
                    else
                        volume_next = up[15:0];
                end
            end else begin
                if (volume_reg <= envelope_step_reg)
                    volume_next = 16'h0000;
                else
                    volume_next = volume_reg - envelope_step_reg;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn)
            volume_reg <= 16'h0000;
        else
            volume_reg <= volume_next;
    end

    // Cadence timers in 125 us ticks
    wire expired   = tick_reg && tone_en && (cadence_reg == 16'h0000) &&
                     (phase_on_reg ? on_tmr_en : off_tmr_en);
    wire on_event  = expired & phase_on_reg;
    wire off_event = expired & ~phase_on_reg;
    reg         phase_on_next;
    reg  [15:0] cadence_next;
    always @* begin
        phase_on_next = phase_on_reg;
        cadence_next  = cadence_reg;
        if (!tone_en) begin
            phase_on_next = 1'b1;
            cadence_next  = on_duration_reg;
        end else if (expired) begin
            if (phase_on_reg && off_tmr_en) begin
                phase_on_next = 1'b0;
                cadence_next  = off_duration_reg;
            end else begin
                // Back to, or staying in, the on phase
                phase_on_next = 1'b1;
                cadence_next  = on_duration_reg;
            end
        end else if (tick_reg && cadence_reg != 16'h0000) begin
            cadence_next = cadence_reg - 16'h0001;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            phase_on_reg <= 1'b1;
            cadence_reg  <= 16'h0000;
        end else begin
            phase_on_reg <= phase_on_next;
            cadence_reg  <= cadence_next;
        end
    end

    // Sticky status, set wins over read clear
    wire [1:0] ev = {off_event, on_event} & irq_mask_one_reg;
    reg  [1:0] irq_status_one_next;
    always @* begin
        irq_status_one_next = irq_status_one_reg;
        if (rd_status)
            irq_status_one_next = 2'h0;
        // Event in the read cycle survives the clear
        irq_status_one_next = irq_status_one_next | ev;
    end

    always @(posedge aclk) begin
        if (!aresetn)
            irq_status_one_reg <= 2'h0;
        else
            irq_status_one_reg <= irq_status_one_next;
    end

    assign irq_n = ~|irq_status_one_reg;
endmodule // tone_gen
`default_nettype wire

// >>> rtl/tone_gen_map.vh
// Register map and constants of the billing tone generator
// Notes on behaviour
// - Oscillator samples at 64 kHz; frequency and amplitude coefficients set the tone.
// - Oscillator serves billing tones above voice band, typically 12 or 16 kHz.
// - Oscillator output is multiplied by envelope volume before the DAC.
// - While on, volume rises from zero toward 7fff by step each 8 kHz tick.
// - Attack ramp freezes while transmit signal exceeds the AGC clip threshold.
// - When off, volume falls to zero by step each 8 kHz tick.
// - On and off cadence timers are 16-bit counts of 125 us.
// - On and off timer expiry each have own status and enable bit.
// - Control holds tone, on timer and off timer enables plus waveform present.
// - Event sets status only when enabled; interrupt pin low while any set.
// - Reading the status register clears its bits.
`ifndef TONE_GEN_MAP_VH
`define TONE_GEN_MAP_VH
`define CLK_HZ            25000000
`define SAMPLE_HZ         64000
`define TICK_HZ           8000
`define SAMPLE_DIV        (`CLK_HZ / `SAMPLE_HZ)
`define SAMPLES_PER_TICK  (`SAMPLE_HZ / `TICK_HZ)
`define VOL_MAX           16'h7fff
`define OFS_CONTROL       8'h00
`define OFS_FREQ          8'h04
`define OFS_AMPL          8'h08
`define OFS_STEP          8'h0c
`define OFS_CLIP          8'h10
`define OFS_ON_TIME       8'h14
`define OFS_OFF_TIME      8'h18
`define OFS_IRQ_STATUS    8'h1c
`define OFS_IRQ_MASK      8'h20
`define OFS_VOLUME        8'h24
`define CTL_TONE_EN       0
`define CTL_ON_TMR_EN     1
`define CTL_OFF_TMR_EN    2
`define CTL_PRESENT       3
`define IRQ_ON_EXP        0
`define IRQ_OFF_EXP       1
`endif
